// *** verilog/ccr_cfg.svh ***
// Offsets, field positions, reset values and codes of the charger
// configuration bank. Definitions only; it is included by the package.
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Seven-bit serial slave address
`define CCR_I2C_ADDR 7'h3F

// Register offsets
`define CCR_OFS_CTRL 8'h00
`define CCR_OFS_IIN 8'h01
`define CCR_OFS_FAST 8'h02
`define CCR_OFS_PRE_TERM 8'h03
`define CCR_OFS_RECHG_VIN 8'h04
`define CCR_OFS_TOPOFF_VB 8'h05

// Field positions in the control byte
`define CCR_RST_BIT 7
`define CCR_LOCK_BIT 4

// Power-on values of whole registers
`define CCR_RST_CTRL 8'h00
`define CCR_RST_IIN 8'h04
`define CCR_RST_FAST 8'hD9
`define CCR_RST_PRE_TERM 8'h43
`define CCR_RST_RECHG_VIN 8'h36
`define CCR_RST_TOPOFF_VB 8'h18

// Largest battery regulation code
`define CCR_VREG_MAX 6'h28

// Input current limit figures in mA
`define CCR_IIN_STEP_MA 12'h064
`define CCR_IIN_F100_MA 12'h064
`define CCR_IIN_F500_MA 12'h1F4
`define CCR_IIN_F900_MA 12'h384
`define CCR_IIN_F1500_MA 12'h5DC
`define CCR_IIN_F2000_MA 12'h7D0
`define CCR_IIN_F3000_MA 12'hBB8

`endif

// *** verilog/ccr_pkg.sv ***
// Types shared by the charger configuration bank.
// Assumes the constants header sits on the include path.
`include "ccr_cfg.svh"

package ccr_pkg;

  // Serial slave states, Gray coded along the write path
  typedef enum logic [3:0] {
    CCR_S_IDLE = 4'h0,
    CCR_S_ADDR = 4'h1,
    CCR_S_AACK = 4'h3,
    CCR_S_PTR = 4'h2,
    CCR_S_PACK = 4'h6,
    CCR_S_WDAT = 4'h7,
    CCR_S_WACK = 4'h5,
    CCR_S_RDAT = 4'h4,
    CCR_S_RACK = 4'hC
  } ccr_state_t;

endpackage : ccr_pkg

// *** verilog/ccr_sync2.sv ***
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module ccr_sync2
(
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_reg; // First stage, read only by the second
  logic meta_next;
  logic q_reg; // Second stage
  logic q_next;

  // Next values: shift the pin through
  always_comb
  begin
    meta_next = d;
    q_next = meta_reg;
  end

  // Idle bus level is high, so reset to one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b1;
      q_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule : ccr_sync2

`default_nettype wire

// *** verilog/ccr_field_guard.sv ***
// Write filter for one locked field: optional clamp, then lock check.
// Assumes narrower fields are zero-extended to six bits by the caller.
`timescale 1ns/1ps
`default_nettype none

module ccr_field_guard
(
  input wire logic [5:0] cur_val,
  input wire logic [5:0] wr_val,
  input wire logic lock,
  input wire logic clamp_en,
  input wire logic [5:0] max_val,
  output logic [5:0] new_val
);

  logic [5:0] clamped; // Written value after the ceiling

  // Clamp first so a locked field is compared against what would land
  always_comb
  begin
    clamped = (clamp_en && (wr_val > max_val)) ? max_val : wr_val;
    new_val = (lock && (clamped > cur_val)) ? cur_val : clamped;
  end

endmodule : ccr_field_guard

`default_nettype wire

// *** verilog/ccr_bank.sv ***
// Charger configuration bank behind a two-wire serial slave port.
// Assumes pull-ups on the bus and a host that drives the serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"

module ccr_bank
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic detect_done,
  input wire logic [4:0] detect_ceiling,
  input wire logic watchdog_expired,
  output logic [2:0] input_limit_select,
  output logic [4:0] input_current_ceiling,
  output logic [11:0] effective_input_limit_ma,
  output logic [1:0] precharge_exit_threshold,
  output logic [5:0] fast_charge_current,
  output logic [3:0] precharge_current,
  output logic [3:0] termination_current,
  output logic recharge_threshold,
  output logic [2:0] trickle_current,
  output logic [3:0] input_voltage_floor,
  output logic [1:0] post_termination_timer,
  output logic [5:0] battery_regulation_voltage,
  output logic charge_setting_lock
);

  logic scl_s; // Synchronised bus clock
  logic sda_s; // Synchronised bus data
  logic scl_d_reg; // Previous sampled levels for edge detection
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  ccr_state_t state_reg; // Slave state
  ccr_state_t state_next;
  logic [3:0] cnt_reg; // Bits moved in the current byte
  logic [3:0] cnt_next;
  logic [7:0] shift_reg; // Byte being received or sent
  logic [7:0] shift_next;
  logic [7:0] ptr_reg; // Register pointer, auto-increments
  logic [7:0] ptr_next;
  logic rnw_reg; // Direction bit of the transaction
  logic rnw_next;
  logic nack_reg; // Host refused the last read byte
  logic nack_next;
  logic oe_reg; // Drives the data line low when set
  logic oe_next;

  logic wr_en; // One-cycle register write strobe
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  logic lock_reg; // Stored lock bit of the control byte
  logic lock_next;
  logic [7:0] iin_reg; // Register 01
  logic [7:0] iin_next;
  logic [7:0] fast_reg; // Register 02
  logic [7:0] fast_next;
  logic [7:0] pt_reg; // Register 03
  logic [7:0] pt_next;
  logic [7:0] rv_reg; // Register 04
  logic [7:0] rv_next;
  logic [7:0] tv_reg; // Register 05
  logic [7:0] tv_next;
  logic [11:0] eff_reg; // Effective input limit in mA
  logic [11:0] eff_next;
  logic soft_rst; // Host wrote the reset bit

  logic [5:0] fcc_g; // Guarded write values
  logic [5:0] pcur_g;
  logic [5:0] vb_g;
  logic [7:0] rd_byte; // Byte at the current pointer

  // Pin levels cross into clk through two flops each
  ccr_sync2 u_sync_scl (.clk(clk), .rst(rst), .d(scl_in), .q(scl_s));
  ccr_sync2 u_sync_sda (.clk(clk), .rst(rst), .d(sda_in), .q(sda_s));

  // Bus events from the synchronised levels
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Read multiplexer; unmapped offsets read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `CCR_OFS_CTRL: v = {3'h0, lock_reg, 4'h0};
      `CCR_OFS_IIN: v = iin_reg;
      `CCR_OFS_FAST: v = fast_reg;
      `CCR_OFS_PRE_TERM: v = pt_reg;
      `CCR_OFS_RECHG_VIN: v = rv_reg;
      `CCR_OFS_TOPOFF_VB: v = tv_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // Process, not assign: it must wake on the registers read inside
  always_comb
  begin
    rd_byte = rd_mux(ptr_reg);
  end

  // Slave next state; start and stop override every state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rnw_next = rnw_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    wr_addr = ptr_reg;
    wr_data = shift_reg;
    if (bus_start)
    begin
      // Fresh or repeated start: listen for the address
      state_next = CCR_S_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (bus_stop)
    begin
      state_next = CCR_S_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        CCR_S_IDLE:
        begin
          oe_next = 1'b0;
        end
        CCR_S_ADDR, CCR_S_PTR, CCR_S_WDAT:
        begin
          // Receive on rising edges, act on the fall after bit 8
          if (scl_rise && (cnt_reg != 4'h8))
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && (cnt_reg == 4'h8))
          begin
            cnt_next = 4'h0;
            if (state_reg == CCR_S_ADDR)
            begin
              if (shift_reg[7:1] == `CCR_I2C_ADDR)
              begin
                rnw_next = shift_reg[0];
                oe_next = 1'b1;
                state_next = CCR_S_AACK;
              end
              else
              begin
                // Not ours: stay off the bus until the next start
                state_next = CCR_S_IDLE;
              end
            end
            else if (state_reg == CCR_S_PTR)
            begin
              ptr_next = shift_reg;
              oe_next = 1'b1;
              state_next = CCR_S_PACK;
            end
            else
            begin
              wr_en = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              oe_next = 1'b1;
              state_next = CCR_S_WACK;
            end
          end
        end
        CCR_S_AACK:
        begin
          if (scl_fall)
          begin
            if (rnw_reg)
            begin
              // First read byte comes from the current pointer
              shift_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_byte[7];
              state_next = CCR_S_RDAT;
            end
            else
            begin
              oe_next = 1'b0;
              state_next = CCR_S_PTR;
            end
          end
        end
        CCR_S_PACK, CCR_S_WACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            state_next = CCR_S_WDAT;
          end
        end
        CCR_S_RDAT:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              // Release for the host's acknowledge
              cnt_next = 4'h0;
              oe_next = 1'b0;
              state_next = CCR_S_RACK;
            end
            else
            begin
              cnt_next = cnt_reg + 4'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        CCR_S_RACK:
        begin
          if (scl_rise)
          begin
            nack_next = sda_s;
          end
          else if (scl_fall)
          begin
            if (nack_reg)
            begin
              state_next = CCR_S_IDLE;
            end
            else
            begin
              shift_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_byte[7];
              state_next = CCR_S_RDAT;
            end
          end
        end
        default:
        begin
          state_next = CCR_S_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= CCR_S_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rnw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rnw_reg <= rnw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // Lock-guarded writes; only battery regulation is clamped
  ccr_field_guard u_guard_fcc (.cur_val(fast_reg[5:0]),
    .wr_val(wr_data[5:0]), .lock(lock_reg), .clamp_en(1'b0),
    .max_val(6'h3F), .new_val(fcc_g));
  ccr_field_guard u_guard_pcur (.cur_val({2'h0, pt_reg[7:4]}),
    .wr_val({2'h0, wr_data[7:4]}), .lock(lock_reg), .clamp_en(1'b0),
    .max_val(6'h3F), .new_val(pcur_g));
  ccr_field_guard u_guard_vb (.cur_val(tv_reg[5:0]),
    .wr_val(wr_data[5:0]), .lock(lock_reg), .clamp_en(1'b1),
    .max_val(`CCR_VREG_MAX), .new_val(vb_g));

  assign soft_rst = wr_en && (wr_addr == `CCR_OFS_CTRL) &&
    wr_data[`CCR_RST_BIT];

  // Register next values; hardware events override a host write
  always_comb
  begin
    lock_next = lock_reg;
    iin_next = iin_reg;
    fast_next = fast_reg;
    pt_next = pt_reg;
    rv_next = rv_reg;
    tv_next = tv_reg;
    if (soft_rst)
    begin
      // Reset bit itself is never stored, so it reads back zero
      lock_next = 1'(`CCR_RST_CTRL >> `CCR_LOCK_BIT);
      iin_next = `CCR_RST_IIN;
      fast_next = `CCR_RST_FAST;
      pt_next = `CCR_RST_PRE_TERM;
      rv_next = `CCR_RST_RECHG_VIN;
      tv_next = `CCR_RST_TOPOFF_VB;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        `CCR_OFS_CTRL: lock_next = wr_data[`CCR_LOCK_BIT];
        `CCR_OFS_IIN: iin_next = wr_data;
        `CCR_OFS_FAST: fast_next = {wr_data[7:6], fcc_g};
        `CCR_OFS_PRE_TERM: pt_next = {pcur_g[3:0], wr_data[3:0]};
        `CCR_OFS_RECHG_VIN: rv_next = wr_data;
        `CCR_OFS_TOPOFF_VB: tv_next = {wr_data[7:6], vb_g};
        default: lock_next = lock_reg;
      endcase
    end
    // Detection result lands even if the host writes in the same cycle
    if (detect_done)
    begin
      iin_next[4:0] = detect_ceiling;
    end
    // Watchdog restores only its marked fields
    if (watchdog_expired)
    begin
      fast_next[5:0] = 6'(`CCR_RST_FAST);
      pt_next = `CCR_RST_PRE_TERM;
      rv_next[7:4] = 4'(`CCR_RST_RECHG_VIN >> 4);
      tv_next[7:6] = 2'(`CCR_RST_TOPOFF_VB >> 6);
    end
  end

  // Effective input limit; code 111 is treated like 000
  always_comb
  begin
    case (iin_reg[7:5])
      3'h1: eff_next = `CCR_IIN_F100_MA;
      3'h2: eff_next = `CCR_IIN_F500_MA;
      3'h3: eff_next = `CCR_IIN_F900_MA;
      3'h4: eff_next = `CCR_IIN_F1500_MA;
      3'h5: eff_next = `CCR_IIN_F2000_MA;
      3'h6: eff_next = `CCR_IIN_F3000_MA;
      default: eff_next = 12'(({7'h00, iin_reg[4:0]} + 12'h001) *
        `CCR_IIN_STEP_MA);
    endcase
  end

  // Bank registers with power-on values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_reg <= 1'b0;
      iin_reg <= `CCR_RST_IIN;
      fast_reg <= `CCR_RST_FAST;
      pt_reg <= `CCR_RST_PRE_TERM;
      rv_reg <= `CCR_RST_RECHG_VIN;
      tv_reg <= `CCR_RST_TOPOFF_VB;
      eff_reg <= `CCR_IIN_F500_MA;
    end
    else
    begin
      lock_reg <= lock_next;
      iin_reg <= iin_next;
      fast_reg <= fast_next;
      pt_reg <= pt_next;
      rv_reg <= rv_next;
      tv_reg <= tv_next;
      eff_reg <= eff_next;
    end
  end

  // Field outputs straight from the stored bits
  assign input_limit_select = iin_reg[7:5];
  assign input_current_ceiling = iin_reg[4:0];
  assign effective_input_limit_ma = eff_reg;
  assign precharge_exit_threshold = fast_reg[7:6];
  assign fast_charge_current = fast_reg[5:0];
  assign precharge_current = pt_reg[7:4];
  assign termination_current = pt_reg[3:0];
  assign recharge_threshold = rv_reg[7];
  assign trickle_current = rv_reg[6:4];
  assign input_voltage_floor = rv_reg[3:0];
  assign post_termination_timer = tv_reg[7:6];
  assign battery_regulation_voltage = tv_reg[5:0];
  assign charge_setting_lock = lock_reg;

  // Checks on the bank behaviour
  a_vreg_ceiling: assert property (@(posedge clk)
    disable iff (rst) battery_regulation_voltage <= 6'h28)
    else $error("battery regulation above ceiling");
  a_lock_vreg: assert property (@(posedge clk) disable iff (rst)
    ($past(lock_reg) && !$past(soft_rst)) |->
    battery_regulation_voltage <= $past(battery_regulation_voltage))
    else $error("locked battery regulation rose");
  a_lock_fast: assert property (@(posedge clk) disable iff (rst)
    ($past(lock_reg) && !$past(soft_rst) && !$past(watchdog_expired)) |->
    fast_charge_current <= $past(fast_charge_current))
    else $error("locked fast charge current rose");
  a_detect_load: assert property (@(posedge clk) disable iff (rst)
    detect_done |=> input_current_ceiling == $past(detect_ceiling))
    else $error("detection result not loaded");
  a_wd_restore: assert property (@(posedge clk) disable iff (rst)
    watchdog_expired |=> (fast_charge_current == 6'h19) &&
    (precharge_current == 4'h4) && (termination_current == 4'h3) &&
    (trickle_current == 3'h3) && !recharge_threshold &&
    (post_termination_timer == 2'h0))
    else $error("watchdog did not restore fields");
  a_soft_reset: assert property (@(posedge clk) disable iff (rst)
    (soft_rst && !detect_done) |=> (iin_reg == 8'h04) &&
    (tv_reg == 8'h18) && !lock_reg && (rv_reg == 8'h36))
    else $error("register reset incomplete");
  a_forced_limit: assert property (@(posedge clk)
    disable iff (rst)
    (input_limit_select == 3'h4) [*2] |-> effective_input_limit_ma == 12'h5DC)
    else $error("forced 1500 mA limit wrong");
  a_follow_field: assert property (@(posedge clk)
    disable iff (rst)
    ($past(input_limit_select) == 3'h0) |-> effective_input_limit_ma ==
    12'(({7'h00, $past(input_current_ceiling)} + 12'h001) * 12'h064))
    else $error("followed limit wrong");
  a_idle_release: assert property (@(posedge clk)
    disable iff (rst)
    (state_reg == CCR_S_IDLE) [*2] |-> !sda_oe)
    else $error("data line driven while idle");
  a_write_commit: assert property (@(posedge clk)
    disable iff (rst)
    (wr_en && (wr_addr == 8'h04) && !watchdog_expired) |=>
    rv_reg == $past(wr_data))
    else $error("written value not stored");

endmodule : ccr_bank

`default_nettype wire

// *** verification/ccr_host_model.sv ***
// Host side of the two-wire bus: a master that clocks bytes in and out.
// Assumes a pull-up outside this model resolves the data line.
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model
(
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // Clocks per quarter bit; slow enough for the slave's sync latency
  localparam int Q = 6;

  // Bus idles with both lines released
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Whole clocks only, so every change lands just after an edge
  task automatic tick();
    repeat (Q) @(posedge clk);
  endtask : tick

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_rel <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_rel <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_rel <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_rel <= 1'b1;
    tick();
  endtask : stop

  // Data set in the low phase and held through the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_rel <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda_line;
    tick();
    scl <= 1'b0;
    tick();
  endtask : bit_io

  // Byte MSB first, then the acknowledge slot carrying ab
  task automatic byte_io(input logic [7:0] w, input logic ab,
    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(w[i], r[i]);
    end
    bit_io(ab, a);
  endtask : byte_io
endmodule : ccr_host_model
`default_nettype wire

// *** verification/charger_config_register_bank_test.sv ***
// Self-checking bench for the charger configuration bank.
// Assumes the bank, its header and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"

module charger_config_register_bank_test;
  logic clk;
  logic rst;
  logic detect_done;
  logic [4:0] detect_ceiling;
  logic watchdog_expired;
  logic scl, sda_rel, sda_oe, sda_out;
  wire logic sda_line;
  logic [2:0] sel;
  logic [4:0] ceil;
  logic [11:0] lim_ma;
  logic [1:0] pexit, tmr;
  logic [5:0] fcc, vb;
  logic [3:0] pcur, tcur, vin;
  logic [2:0] trk;
  logic rchg, lock;
  int fails = 0;
  int tests_run = 0;

  // Open-drain data line with pull-up: low if either side pulls
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

  ccr_bank dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .detect_done(detect_done),
    .detect_ceiling(detect_ceiling), .watchdog_expired(watchdog_expired),
    .input_limit_select(sel), .input_current_ceiling(ceil),
    .effective_input_limit_ma(lim_ma), .precharge_exit_threshold(pexit),
    .fast_charge_current(fcc), .precharge_current(pcur),
    .termination_current(tcur), .recharge_threshold(rchg),
    .trickle_current(trk), .input_voltage_floor(vin),
    .post_termination_timer(tmr), .battery_regulation_voltage(vb),
    .charge_setting_lock(lock));

  ccr_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_rel));

  // One counted comparison
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single write; all three bytes must be acknowledged
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    host.start();
    host.byte_io({`CCR_I2C_ADDR, 1'b0}, 1'b1, r, a0);
    host.byte_io(ofs, 1'b1, r, a1);
    host.byte_io(d, 1'b1, r, a2);
    host.stop();
    chk({9'h000, a0, a1, a2}, 12'h000);
  endtask : wr

  // Pointer write, repeated start, one byte read ended by a NACK
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] r, d;
    logic a0, a1, a2, a3;
    host.start();
    host.byte_io({`CCR_I2C_ADDR, 1'b0}, 1'b1, r, a0);
    host.byte_io(ofs, 1'b1, r, a1);
    host.start();
    host.byte_io({`CCR_I2C_ADDR, 1'b1}, 1'b1, r, a2);
    host.byte_io(8'hFF, 1'b1, d, a3);
    host.stop();
    chk({9'h000, a0, a1, a2}, 12'h000);
    chk({4'h0, d}, {4'h0, exp});
  endtask : rd_chk

  // Power-on values, shared by the reset and soft reset scenarios
  task automatic chk_defaults();
    rd_chk(`CCR_OFS_CTRL, 8'h00);
    rd_chk(`CCR_OFS_IIN, 8'h04);
    rd_chk(`CCR_OFS_FAST, 8'hD9);
    rd_chk(`CCR_OFS_PRE_TERM, 8'h43);
    rd_chk(`CCR_OFS_RECHG_VIN, 8'h36);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h18);
    chk(lim_ma, 12'h1F4);
  endtask : chk_defaults

  // Fields land on their own outputs; every timer code is accepted
  task automatic test_fields();
    wr(`CCR_OFS_RECHG_VIN, 8'hAA);
    chk({rchg, trk, vin}, 12'h0AA);
    wr(`CCR_OFS_FAST, 8'h6A);
    chk({pexit, fcc}, 12'h06A);
    wr(`CCR_OFS_PRE_TERM, 8'h9C);
    chk({pcur, tcur}, 12'h09C);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CCR_OFS_TOPOFF_VB, {i[1:0], 6'h10});
      chk(12'(tmr), 12'(i));
    end
    $display("test fields done");
  endtask : test_fields

  // Every mode code with ceiling 9, then both ceiling extremes
  task automatic test_limits();
    logic [11:0] t [8] = '{12'h3E8, 12'h064, 12'h1F4, 12'h384,
      12'h5DC, 12'h7D0, 12'hBB8, 12'h3E8};
    for (int i = 0; i < 8; i++)
    begin
      wr(`CCR_OFS_IIN, {i[2:0], 5'h09});
      repeat (2) @(posedge clk);
      chk(lim_ma, t[i]);
    end
    wr(`CCR_OFS_IIN, 8'h00);
    repeat (2) @(posedge clk);
    chk(lim_ma, 12'h064);
    wr(`CCR_OFS_IIN, 8'h1F);
    repeat (2) @(posedge clk);
    chk(lim_ma, 12'hC80);
    $display("test limits done");
  endtask : test_limits

  // Detection loads the ceiling; the host may overwrite it later
  task automatic test_detect();
    detect_ceiling <= 5'h0E;
    detect_done <= 1'b1;
    @(posedge clk);
    detect_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk(lim_ma, 12'h5DC);
    chk({4'h0, sel, ceil}, 12'h00E);
    rd_chk(`CCR_OFS_IIN, 8'h0E);
    wr(`CCR_OFS_IIN, 8'h03);
    repeat (2) @(posedge clk);
    chk(lim_ma, 12'h190);
    $display("test detect done");
  endtask : test_detect

  // Regulation codes above the top are limited; a code below the top stands
  task automatic test_clamp();
    wr(`CCR_OFS_TOPOFF_VB, 8'hFF);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'hE8);
    wr(`CCR_OFS_TOPOFF_VB, 8'h29);
    chk(12'(vb), 12'h028);
    wr(`CCR_OFS_TOPOFF_VB, 8'h27);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h27);
    $display("test clamp done");
  endtask : test_clamp

  // Locked fields only go down; neighbours in the same byte still move
  task automatic test_lock();
    wr(`CCR_OFS_CTRL, 8'h5F);
    rd_chk(`CCR_OFS_CTRL, 8'h10);
    chk(12'(lock), 12'h001);
    wr(`CCR_OFS_TOPOFF_VB, 8'h28);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h27);
    wr(`CCR_OFS_TOPOFF_VB, 8'h20);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h20);
    wr(`CCR_OFS_FAST, 8'h2B);
    rd_chk(`CCR_OFS_FAST, 8'h2A);
    wr(`CCR_OFS_FAST, 8'h45);
    chk({pexit, fcc}, 12'h045);
    wr(`CCR_OFS_PRE_TERM, 8'hAF);
    rd_chk(`CCR_OFS_PRE_TERM, 8'h9F);
    wr(`CCR_OFS_PRE_TERM, 8'h51);
    chk({pcur, tcur}, 12'h051);
    $display("test lock done");
  endtask : test_lock

  // Expiry restores only the marked fields
  task automatic test_watchdog();
    wr(`CCR_OFS_TOPOFF_VB, 8'hD0);
    watchdog_expired <= 1'b1;
    @(posedge clk);
    watchdog_expired <= 1'b0;
    rd_chk(`CCR_OFS_FAST, 8'h59);
    rd_chk(`CCR_OFS_PRE_TERM, 8'h43);
    rd_chk(`CCR_OFS_RECHG_VIN, 8'h3A);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h10);
    rd_chk(`CCR_OFS_IIN, 8'h03);
    $display("test watchdog done");
  endtask : test_watchdog

  // Soft reset, then a foreign address that must be ignored
  task automatic test_reset_addr();
    logic [7:0] r;
    logic a0, a1, a2;
    wr(`CCR_OFS_CTRL, 8'h80);
    chk_defaults();
    host.start();
    host.byte_io(8'h7C, 1'b1, r, a0);
    host.byte_io(`CCR_OFS_TOPOFF_VB, 1'b1, r, a1);
    host.byte_io(8'h00, 1'b1, r, a2);
    host.stop();
    chk({9'h000, a0, a1, a2}, 12'h007);
    rd_chk(`CCR_OFS_TOPOFF_VB, 8'h18);
    rd_chk(8'h10, 8'h00);
    $display("test reset and address done");
  endtask : test_reset_addr

  // Verdict; the only way the run ends
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Free-running clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang at about twice the expected 46k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    detect_done = 1'b0;
    detect_ceiling = 5'h00;
    watchdog_expired = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk_defaults();
    $display("test reset done");
    test_fields();
    test_limits();
    test_detect();
    test_clamp();
    test_lock();
    test_watchdog();
    test_reset_addr();
    complete_run();
  end
endmodule : charger_config_register_bank_test
`default_nettype wire
